// [design/uepc_pkg.sv]
// Purpose: Shared constants and types for the endpoint control block
// Assumes: 16-bit core-bus registers at their printed byte addresses
// Notes:   All fields reset to zero
`default_nettype none
package uepc_pkg;

  localparam logic [31:0] ADDR_RX_CONTROL_EP1      = 32'h5000185E;
  localparam logic [31:0] ADDR_ENDPOINT_CONFIG_EP3 = 32'h50001860;
  localparam logic [31:0] ADDR_TX_DATA_EP2         = 32'h50001862;

  // Receive control fields
  localparam int RXC_RX_EN_BIT  = 0;
  localparam int RXC_IGN_SU_BIT = 2;
  localparam int RXC_FLUSH_BIT  = 3;

  // Endpoint configuration fields
  localparam int EPC_EP_LSB     = 0;
  localparam int EPC_EP_MSB     = 3;
  localparam int EPC_EN_BIT     = 4;
  localparam int EPC_ISO_BIT    = 5;
  localparam int EPC_STALL_BIT  = 7;

  localparam int TXD_BYTE_MSB   = 7;

  localparam logic        RST_BIT   = 1'h0;
  localparam logic [3:0]  RST_EP    = 4'h0;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;

  // USB packet identifiers and CRC16 constants
  localparam logic [7:0]  PID_DATA0 = 8'hC3;
  localparam logic [7:0]  PID_DATA1 = 8'h4B;
  localparam logic [15:0] CRC_INIT  = 16'hFFFF;
  localparam logic [15:0] CRC_POLY  = 16'hA001;

  typedef enum logic [1:0] {
    UEPC_TOK_OUT,
    UEPC_TOK_IN,
    UEPC_TOK_SETUP,
    UEPC_TOK_OTHER
  } uepc_tok_kind_t;

  typedef enum logic [1:0] {
    UEPC_HS_ACK,
    UEPC_HS_NAK,
    UEPC_HS_STALL
  } uepc_hs_t;

  typedef struct packed {
    logic           valid;
    uepc_tok_kind_t kind;
    logic [6:0]     addr;
    logic [3:0]     ep;
  } uepc_token_t;

  typedef struct packed {
    logic     valid;
    uepc_hs_t code;
  } uepc_resp_t;

endpackage : uepc_pkg
`default_nettype wire

// [design/uepc_top.sv]
// Purpose: Endpoint receive control, configuration and transmit data port
// Assumes: Token decoder and receive engine run on clk
// Notes:   Outputs are registered
// Notes on behaviour
// - Flush empties receive FIFO, idles endpoint
// - Flush waits while reception is in progress
// - Ignore-setup bit drops matching SETUP tokens
// - OUT reception disabled after packet or stall
// - SETUP accepted whatever receive enable says
// - Back-to-back SETUP: drop data, still ACK
// - Otherwise unacceptable SETUP gets no handshake
// - Stall plus transmit enabled: IN gets STALL
// - Stall plus receive enabled: OUT gets STALL
// - Stall never answers a SETUP token
// - Isochronous endpoint never sends NAK
// - Match endpoint number with function address
// - Disabled endpoint answers no token
// - Endpoint number is low four bits
// - Data port write pushes one byte
// - Device adds PID and CRC16 itself
// - Test mode makes data port readable
`timescale 1ns/1ps
`default_nettype none
module uepc_top #(
  parameter int TX_DEPTH = 64
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic [31:0]          reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [15:0]          reg_wdata,
  output logic [15:0]               reg_rdata,
  input  wire logic                 test_mode,
  input  wire logic [6:0]           function_address_reg,
  input  wire logic                 tx_fifo_en,
  input  wire uepc_pkg::uepc_token_t tok,
  input  wire logic                 rx_busy,
  input  wire logic                 rx_fifo_full,
  input  wire logic                 rx_pkt_done,
  input  wire logic                 rx_pkt_ok,
  input  wire logic                 tx_pid_data1,
  input  wire logic                 tx_ready,
  output var uepc_pkg::uepc_resp_t  resp,
  output logic                      rx_store,
  output logic                      rx_drop,
  output logic                      fifo_flush,
  output logic                      tx_valid,
  output logic [7:0]                tx_data,
  output logic                      tx_last
);

  localparam int AW = $clog2(TX_DEPTH);

  if (TX_DEPTH < 2 || (1 << AW) != TX_DEPTH) begin : g_depth_check
    $error("TX_DEPTH must be a power of two of at least 2");
  end

  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ b[i]) begin
        c = (c >> 1) ^ uepc_pkg::CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction : crc16_byte

  typedef enum logic [2:0] {TX_IDLE, TX_PID, TX_DATA, TX_CRC_LO, TX_CRC_HI} uepc_tx_state_t;

  logic           rx_en_r, ign_setup_r, flush_pend_r;
  logic           stall_r, iso_r, ep_en_r;
  logic [3:0]     endpoint_number_r;
  logic [7:0]     tx_fifo_byte_r;
  logic           setup_seen_r;
  logic           armed_r, armed_setup_r, armed_drop_r;
  logic           tx_start_r;
  uepc_tx_state_t tx_state_r;
  logic [15:0]    crc_r;
  logic [7:0]     mem [TX_DEPTH];
  logic [AW:0]    wr_ptr_r, rd_ptr_r;

  wire sel_rxc = reg_addr == uepc_pkg::ADDR_RX_CONTROL_EP1;
  wire sel_epc = reg_addr == uepc_pkg::ADDR_ENDPOINT_CONFIG_EP3;
  wire sel_txd = reg_addr == uepc_pkg::ADDR_TX_DATA_EP2;
  wire wr_rxc  = reg_wr && sel_rxc;
  wire wr_epc  = reg_wr && sel_epc;
  wire wr_txd  = reg_wr && sel_txd;

  wire tx_empty = wr_ptr_r == rd_ptr_r;
  wire tx_full  = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);

  // Token qualification
  wire tok_match = tok.valid && ep_en_r && tok.addr == function_address_reg
                   && tok.ep == endpoint_number_r;
  wire is_in    = tok_match && tok.kind == uepc_pkg::UEPC_TOK_IN;
  wire is_out   = tok_match && tok.kind == uepc_pkg::UEPC_TOK_OUT;
  wire is_setup = tok_match && tok.kind == uepc_pkg::UEPC_TOK_SETUP && !ign_setup_r;
  wire flush_go = flush_pend_r && !rx_busy;

  wire out_stall  = is_out && stall_r && rx_en_r;
  wire out_accept = is_out && !stall_r && rx_en_r && !rx_fifo_full;
  wire out_nak    = is_out && !out_stall && !out_accept && !iso_r;
  wire in_stall   = is_in && stall_r && tx_fifo_en;
  wire in_send    = is_in && !in_stall && tx_fifo_en && !tx_empty && tx_state_r == TX_IDLE;
  wire in_nak     = is_in && !in_stall && !in_send && !iso_r;
  // SETUP ignores stall and receive enable
  wire su_drop    = is_setup && setup_seen_r;
  wire su_accept  = is_setup && !setup_seen_r && !rx_fifo_full && !rx_busy;
  wire pkt_end    = armed_r && rx_pkt_done;

  // Receive control register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_en_r     <= uepc_pkg::RST_BIT;
      ign_setup_r <= uepc_pkg::RST_BIT;
    end else begin
      if (wr_rxc) begin
        rx_en_r     <= reg_wdata[uepc_pkg::RXC_RX_EN_BIT];
        ign_setup_r <= reg_wdata[uepc_pkg::RXC_IGN_SU_BIT];
      end else if (out_stall || (pkt_end && !armed_setup_r)) begin
        rx_en_r <= 1'b0;
      end
    end
  end

  // Flush request, held until receive engine is idle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flush_pend_r <= uepc_pkg::RST_BIT;
      fifo_flush   <= uepc_pkg::RST_BIT;
    end else begin
      fifo_flush <= flush_go;
      if (wr_rxc && reg_wdata[uepc_pkg::RXC_FLUSH_BIT]) begin
        flush_pend_r <= 1'b1;
      end else if (flush_go) begin
        flush_pend_r <= 1'b0;
      end
    end
  end

  // Endpoint configuration register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stall_r           <= uepc_pkg::RST_BIT;
      iso_r             <= uepc_pkg::RST_BIT;
      ep_en_r           <= uepc_pkg::RST_BIT;
      endpoint_number_r <= uepc_pkg::RST_EP;
    end else if (wr_epc) begin
      stall_r           <= reg_wdata[uepc_pkg::EPC_STALL_BIT];
      iso_r             <= reg_wdata[uepc_pkg::EPC_ISO_BIT];
      ep_en_r           <= reg_wdata[uepc_pkg::EPC_EN_BIT];
      endpoint_number_r <= reg_wdata[uepc_pkg::EPC_EP_MSB:uepc_pkg::EPC_EP_LSB];
    end
  end

  // Register read-back
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= uepc_pkg::RST_WORD;
    end else if (reg_rd) begin
      reg_rdata <= uepc_pkg::RST_WORD;
      if (sel_rxc) begin
        reg_rdata[uepc_pkg::RXC_RX_EN_BIT]  <= rx_en_r;
        reg_rdata[uepc_pkg::RXC_IGN_SU_BIT] <= ign_setup_r;
        reg_rdata[uepc_pkg::RXC_FLUSH_BIT]  <= flush_pend_r;
      end else if (sel_epc) begin
        reg_rdata[uepc_pkg::EPC_STALL_BIT] <= stall_r;
        reg_rdata[uepc_pkg::EPC_ISO_BIT]   <= iso_r;
        reg_rdata[uepc_pkg::EPC_EN_BIT]    <= ep_en_r;
        reg_rdata[uepc_pkg::EPC_EP_MSB:uepc_pkg::EPC_EP_LSB] <= endpoint_number_r;
      end else if (sel_txd && test_mode) begin
        reg_rdata[uepc_pkg::TXD_BYTE_MSB:0] <= tx_fifo_byte_r;
      end
    end
  end

  // Back-to-back SETUP tracking
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      setup_seen_r <= uepc_pkg::RST_BIT;
    end else if (pkt_end && armed_setup_r && !armed_drop_r && rx_pkt_ok) begin
      setup_seen_r <= 1'b1;
    end else if (flush_go || (tok_match && tok.kind != uepc_pkg::UEPC_TOK_SETUP)) begin
      setup_seen_r <= 1'b0;
    end
  end

  // Data phase bookkeeping for an accepted OUT or SETUP
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      armed_r       <= uepc_pkg::RST_BIT;
      armed_setup_r <= uepc_pkg::RST_BIT;
      armed_drop_r  <= uepc_pkg::RST_BIT;
      rx_store      <= uepc_pkg::RST_BIT;
      rx_drop       <= uepc_pkg::RST_BIT;
    end else if (out_accept || su_accept || su_drop) begin
      armed_r       <= 1'b1;
      armed_setup_r <= is_setup;
      armed_drop_r  <= su_drop;
      rx_store      <= !su_drop;
      rx_drop       <= su_drop;
    end else if (rx_pkt_done || flush_go) begin
      armed_r  <= 1'b0;
      rx_store <= 1'b0;
      rx_drop  <= 1'b0;
    end
  end

  // Handshake decision
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      resp.valid <= uepc_pkg::RST_BIT;
      resp.code  <= uepc_pkg::UEPC_HS_ACK;
    end else begin
      resp.valid <= 1'b0;
      if (out_stall || in_stall) begin
        resp.valid <= 1'b1;
        resp.code  <= uepc_pkg::UEPC_HS_STALL;
      end else if (out_nak || in_nak) begin
        resp.valid <= 1'b1;
        resp.code  <= uepc_pkg::UEPC_HS_NAK;
      end else if (pkt_end && rx_pkt_ok && !(iso_r && !armed_setup_r)) begin
        resp.valid <= 1'b1;
        resp.code  <= uepc_pkg::UEPC_HS_ACK;
      end
    end
  end

  // Transmit data port and FIFO fill
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_fifo_byte_r <= uepc_pkg::RST_BYTE;
      wr_ptr_r       <= '0;
    end else if (wr_txd) begin
      tx_fifo_byte_r <= reg_wdata[uepc_pkg::TXD_BYTE_MSB:0];
      if (!tx_full) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (wr_txd && !tx_full) begin
      mem[wr_ptr_r[AW-1:0]] <= reg_wdata[uepc_pkg::TXD_BYTE_MSB:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_start_r <= uepc_pkg::RST_BIT;
    end else begin
      tx_start_r <= in_send;
    end
  end

  // Packet framer: PID, payload, CRC16
  wire tx_adv = !tx_valid || tx_ready;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_state_r <= TX_IDLE;
      tx_valid   <= uepc_pkg::RST_BIT;
      tx_data    <= uepc_pkg::RST_BYTE;
      tx_last    <= uepc_pkg::RST_BIT;
      crc_r      <= uepc_pkg::CRC_INIT;
      rd_ptr_r   <= '0;
    end else if (tx_adv) begin
      unique case (tx_state_r)
        TX_IDLE: begin
          tx_valid <= 1'b0;
          tx_last  <= 1'b0;
          if (tx_start_r) begin
            tx_valid   <= 1'b1;
            tx_data    <= tx_pid_data1 ? uepc_pkg::PID_DATA1 : uepc_pkg::PID_DATA0;
            crc_r      <= uepc_pkg::CRC_INIT;
            tx_state_r <= TX_DATA;
          end
        end
        TX_PID: begin
          tx_state_r <= TX_DATA;
        end
        TX_DATA: begin
          tx_valid <= 1'b1;
          if (tx_empty) begin
            tx_data    <= ~crc_r[7:0];
            tx_state_r <= TX_CRC_HI;
          end else begin
            tx_data  <= mem[rd_ptr_r[AW-1:0]];
            crc_r    <= crc16_byte(crc_r, mem[rd_ptr_r[AW-1:0]]);
            rd_ptr_r <= rd_ptr_r + 1'b1;
          end
        end
        TX_CRC_LO: begin
          tx_state_r <= TX_CRC_HI;
        end
        TX_CRC_HI: begin
          tx_data    <= ~crc_r[15:8];
          tx_last    <= 1'b1;
          tx_state_r <= TX_IDLE;
        end
      endcase
    end
  end

  // Checks
  a_flush_waits: assert property (@(posedge clk) disable iff (!rst_b)
    rx_busy |=> !fifo_flush)
    else $error("flush while receiving");
  a_flush_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    flush_pend_r && !rx_busy && !(wr_rxc) |=> fifo_flush && !flush_pend_r)
    else $error("flush not executed");
  a_stall_in: assert property (@(posedge clk) disable iff (!rst_b)
    is_in && stall_r && tx_fifo_en |=> resp.valid && resp.code == uepc_pkg::UEPC_HS_STALL)
    else $error("IN not stalled");
  a_stall_out_dis: assert property (@(posedge clk) disable iff (!rst_b)
    is_out && stall_r && rx_en_r && !wr_rxc |=> resp.code == uepc_pkg::UEPC_HS_STALL && !rx_en_r)
    else $error("OUT stall wrong");
  a_setup_nostall: assert property (@(posedge clk) disable iff (!rst_b)
    tok_match && tok.kind == uepc_pkg::UEPC_TOK_SETUP && !(tok.valid && tok.kind != uepc_pkg::UEPC_TOK_SETUP)
    |=> !(resp.valid && resp.code == uepc_pkg::UEPC_HS_STALL))
    else $error("SETUP stalled");
  a_iso_no_nak: assert property (@(posedge clk) disable iff (!rst_b)
    iso_r && !$past(wr_epc) |-> !(resp.valid && resp.code == uepc_pkg::UEPC_HS_NAK))
    else $error("NAK on iso");
  a_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    tok.valid && !ep_en_r |=> !resp.valid || $past(pkt_end))
    else $error("disabled endpoint answered");
  a_ignore_setup: assert property (@(posedge clk) disable iff (!rst_b)
    ign_setup_r && tok.kind == uepc_pkg::UEPC_TOK_SETUP && tok.valid |=> !rx_store && !rx_drop
    || $past(armed_r))
    else $error("ignored SETUP accepted");
  a_setup_dup_drop: assert property (@(posedge clk) disable iff (!rst_b)
    su_drop |=> rx_drop && !rx_store)
    else $error("duplicate SETUP stored");
  a_rx_en_out: assert property (@(posedge clk) disable iff (!rst_b)
    is_out && !rx_en_r && !stall_r && !iso_r |=> resp.valid && resp.code == uepc_pkg::UEPC_HS_NAK)
    else $error("OUT taken while disabled");
  a_push_count: assert property (@(posedge clk) disable iff (!rst_b)
    wr_txd && !tx_full |=> wr_ptr_r == $past(wr_ptr_r) + 1'b1)
    else $error("byte not pushed");
  a_pid_first: assert property (@(posedge clk) disable iff (!rst_b)
    tx_start_r && tx_state_r == TX_IDLE && tx_adv |=> tx_valid
    && (tx_data == uepc_pkg::PID_DATA0 || tx_data == uepc_pkg::PID_DATA1))
    else $error("PID missing");
  a_test_read: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && sel_txd && !test_mode |=> reg_rdata == uepc_pkg::RST_WORD)
    else $error("data port readable outside test");

  c_in_data:  cover property (@(posedge clk) disable iff (!rst_b) tx_valid && tx_last && tx_ready);
  c_out_ack:  cover property (@(posedge clk) disable iff (!rst_b)
    resp.valid && resp.code == uepc_pkg::UEPC_HS_ACK && !rx_en_r);
  c_dup_setup: cover property (@(posedge clk) disable iff (!rst_b) su_drop);
  c_late_flush: cover property (@(posedge clk) disable iff (!rst_b)
    flush_pend_r && rx_busy ##1 !rx_busy ##1 fifo_flush);

endmodule : uepc_top
`default_nettype wire

// [sim/uepc_host_model.sv]
// Purpose: Host and receive-engine model facing the endpoint block
// Assumes: Everything is driven at the falling edge of clk
// Notes:   tx_ready alternates, so stream bytes are taken both at once and after a stall
`timescale 1ns/1ps
`default_nettype none
module uepc_host_model (
  input  wire logic             clk,
  output var uepc_pkg::uepc_token_t tok,
  output logic                  rx_busy,
  output logic                  rx_fifo_full,
  output logic                  rx_pkt_done,
  output logic                  rx_pkt_ok,
  output logic                  tx_ready,
  input  wire logic             tx_valid,
  input  wire logic [7:0]       tx_data,
  input  wire logic             tx_last
);
  logic [7:0] got_q[$];
  logic       got_last;

  initial begin
    tok = '0;
    rx_busy = 1'b0;
    rx_fifo_full = 1'b0;
    rx_pkt_done = 1'b0;
    rx_pkt_ok = 1'b0;
    tx_ready = 1'b0;
    got_last = 1'b0;
  end

  always @(negedge clk) begin
    tx_ready <= ~tx_ready;
  end

  // Sink of the transmit stream
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got_q.push_back(tx_data);
      got_last = tx_last;
    end
  end

  task automatic token(input uepc_pkg::uepc_tok_kind_t k, input logic [6:0] a, input logic [3:0] e);
    tok = {1'b1, k, a, e};
    @(negedge clk);
    // Idle fields inverted so stale values never look valid
    tok = {1'b0, ~tok[12:0]};
    repeat (3) @(negedge clk);
  endtask : token

  task automatic packet(input logic ok);
    rx_busy = 1'b1;
    repeat (3) @(negedge clk);
    rx_pkt_done = 1'b1;
    rx_pkt_ok = ok;
    @(negedge clk);
    rx_pkt_done = 1'b0;
    rx_pkt_ok = ~ok;
    rx_busy = 1'b0;
    repeat (3) @(negedge clk);
  endtask : packet

  task automatic set_levels(input logic busy, input logic full);
    rx_busy = busy;
    rx_fifo_full = full;
  endtask : set_levels
endmodule : uepc_host_model
`default_nettype wire

// [sim/tb_usb_endpoint_rx_ctrl_config_tx_data.sv]
// Purpose: Self-checking bench for endpoint receive control, config and tx data port
// Assumes: Function address 0x2A, endpoint 5, DATA0 then DATA1 packets
// Notes:   Register accesses are one-cycle strobes issued at the falling edge, followed by one idle cycle
`timescale 1ns/1ps
`default_nettype none
module tb_usb_endpoint_rx_ctrl_config_tx_data;
  localparam logic [31:0] A_RXC = uepc_pkg::ADDR_RX_CONTROL_EP1;
  localparam logic [31:0] A_EPC = uepc_pkg::ADDR_ENDPOINT_CONFIG_EP3;
  localparam logic [31:0] A_TXD = uepc_pkg::ADDR_TX_DATA_EP2;
  localparam uepc_pkg::uepc_tok_kind_t T_OUT = uepc_pkg::UEPC_TOK_OUT;
  localparam uepc_pkg::uepc_tok_kind_t T_IN  = uepc_pkg::UEPC_TOK_IN;
  localparam uepc_pkg::uepc_tok_kind_t T_SU  = uepc_pkg::UEPC_TOK_SETUP;
  localparam logic [1:0] ACK = 2'h0;
  localparam logic [1:0] NAK = 2'h1;
  localparam logic [1:0] STL = 2'h2;

  logic                  clk, rst_b, reg_wr, reg_rd, test_mode, tx_fifo_en, tx_pid_data1;
  logic [31:0]           reg_addr;
  logic [15:0]           reg_wdata, reg_rdata, v;
  logic [6:0]            function_address_reg;
  uepc_pkg::uepc_token_t tok;
  logic                  rx_busy, rx_fifo_full, rx_pkt_done, rx_pkt_ok, tx_ready;
  uepc_pkg::uepc_resp_t  resp;
  logic                  rx_store, rx_drop, fifo_flush, tx_valid, tx_last;
  logic [7:0]            tx_data;
  logic [7:0]            exp_b[5];
  logic [15:0]           crc;
  int                    mismatches, comparisons, n_resp, n_flush;
  logic [1:0]            last_code;

  uepc_top #(.TX_DEPTH(8)) DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .test_mode(test_mode),
    .function_address_reg(function_address_reg), .tx_fifo_en(tx_fifo_en), .tok(tok), .rx_busy(rx_busy),
    .rx_fifo_full(rx_fifo_full), .rx_pkt_done(rx_pkt_done), .rx_pkt_ok(rx_pkt_ok),
    .tx_pid_data1(tx_pid_data1), .tx_ready(tx_ready), .resp(resp), .rx_store(rx_store), .rx_drop(rx_drop),
    .fifo_flush(fifo_flush), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last));

  uepc_host_model host (.clk(clk), .tok(tok), .rx_busy(rx_busy), .rx_fifo_full(rx_fifo_full),
    .rx_pkt_done(rx_pkt_done), .rx_pkt_ok(rx_pkt_ok), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (resp.valid === 1'b1) begin
      n_resp++;
      last_code = resp.code;
    end
    if (fifo_flush === 1'b1)
      n_flush++;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [15:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic rsp(input int n, input logic [1:0] code);
    chk("resp count", 16'(n), 16'(n_resp));
    if (n > 0)
      chk("resp code", {14'h0, code}, {14'h0, last_code});
    n_resp = 0;
  endtask : rsp

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  initial begin
    {rst_b, reg_wr, reg_rd, test_mode, tx_pid_data1} = '0;
    {mismatches, comparisons, n_resp, n_flush} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    tx_fifo_en = 1'b1;
    function_address_reg = 7'h2A;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    rd(A_RXC, v); chk("rxc reset", 16'h0000, v);
    rd(A_EPC, v); chk("epc reset", 16'h0000, v);
    rd(A_TXD, v); chk("txd read", 16'h0000, v);
    rd(32'h50001864, v); chk("unmapped", 16'h0000, v);
    wr(A_EPC, 16'hFF40); rd(A_EPC, v); chk("epc reserved", 16'h0000, v);
    wr(A_RXC, 16'hFFF2); rd(A_RXC, v); chk("rxc reserved", 16'h0000, v);
    wr(A_TXD, 16'hAB12);
    test_mode = 1'b1;
    wr(A_TXD, 16'h0034); rd(A_TXD, v); chk("txd test read", 16'h0034, v);
    test_mode = 1'b0;
    n_flush = 0;
    host.set_levels(1'b1, 1'b0);
    wr(A_RXC, 16'h0008); rd(A_RXC, v); chk("flush pending", 16'h0008, v);
    repeat (5) @(negedge clk);
    chk("flush held", 16'h0, 16'(n_flush));
    host.set_levels(1'b0, 1'b0);
    repeat (4) @(negedge clk);
    chk("flush pulse", 16'h1, 16'(n_flush));
    rd(A_RXC, v); chk("flush done", 16'h0000, v);
    wr(A_EPC, 16'h0015); rd(A_EPC, v); chk("epc value", 16'h0015, v);
    wr(A_RXC, 16'h0001);
    host.token(T_OUT, 7'h2A, 4'h5); chk("rx_store out", 16'h1, 16'(rx_store));
    host.packet(1'b1); rsp(1, ACK);
    rd(A_RXC, v); chk("rx_en cleared", 16'h0000, v);
    host.token(T_OUT, 7'h2A, 4'h5); rsp(1, NAK);
    wr(A_RXC, 16'h0001);
    wr(A_EPC, 16'h0095);
    host.token(T_OUT, 7'h2A, 4'h5); rsp(1, STL);
    rd(A_RXC, v); chk("rx_en after stall", 16'h0000, v);
    host.token(T_OUT, 7'h2A, 4'h5); rsp(1, NAK);
    host.token(T_IN, 7'h2A, 4'h5); rsp(1, STL);
    tx_fifo_en = 1'b0;
    host.token(T_IN, 7'h2A, 4'h5); rsp(1, NAK);
    tx_fifo_en = 1'b1;
    host.token(T_SU, 7'h2A, 4'h5); rsp(0, ACK);
    chk("rx_store setup", 16'h1, 16'(rx_store));
    host.packet(1'b1); rsp(1, ACK);
    host.token(T_SU, 7'h2A, 4'h5); chk("rx_drop", 16'h1, 16'(rx_drop));
    host.packet(1'b1); rsp(1, ACK);
    wr(A_EPC, 16'h0015);
    host.token(T_OUT, 7'h2A, 4'h5); rsp(1, NAK);
    host.set_levels(1'b0, 1'b1);
    host.token(T_SU, 7'h2A, 4'h5); rsp(0, ACK);
    chk("rx_store full", 16'h0, 16'(rx_store));
    host.set_levels(1'b0, 1'b0);
    wr(A_RXC, 16'h0004);
    host.token(T_SU, 7'h2A, 4'h5); rsp(0, ACK);
    chk("rx_store ignored", 16'h0, 16'(rx_store));
    wr(A_RXC, 16'h0000);
    host.token(T_OUT, 7'h2B, 4'h5); rsp(0, ACK);
    host.token(T_OUT, 7'h2A, 4'h6); rsp(0, ACK);
    wr(A_EPC, 16'h0005);
    host.token(T_IN, 7'h2A, 4'h5); rsp(0, ACK);
    wr(A_EPC, 16'h0015);
    exp_b = '{uepc_pkg::PID_DATA0, 8'h12, 8'h34, 8'h00, 8'h00};
    crc = uepc_pkg::CRC_INIT;
    for (int i = 0; i < 16; i++)
      crc = (crc[0] ^ (i < 8 ? exp_b[1][i] : exp_b[2][i - 8])) ? (crc >> 1) ^ uepc_pkg::CRC_POLY : crc >> 1;
    exp_b[3] = ~crc[7:0];
    exp_b[4] = ~crc[15:8];
    host.token(T_IN, 7'h2A, 4'h5);
    for (int i = 0; i < 60 && host.got_last !== 1'b1; i++)
      @(negedge clk);
    if (host.got_last === 1'b1) begin
      chk("tx count", 16'd5, 16'(host.got_q.size()));
      for (int i = 0; i < 5; i++)
        chk("tx byte", {8'h00, exp_b[i]}, {8'h00, host.got_q[i]});
      rsp(0, ACK);
      wr(A_EPC, 16'h0035);
      host.token(T_IN, 7'h2A, 4'h5); rsp(0, ACK);
      host.token(T_OUT, 7'h2A, 4'h5); rsp(0, ACK);
      tx_pid_data1 = 1'b1;
      wr(A_EPC, 16'h0015);
      wr(A_TXD, 16'h0056);
      host.got_q.delete();
      host.got_last = 1'b0;
      host.token(T_IN, 7'h2A, 4'h5);
      for (int i = 0; i < 60 && host.got_last !== 1'b1; i++)
        @(negedge clk);
      chk("tx count data1", 16'd4, 16'(host.got_q.size()));
      chk("tx pid data1", {8'h00, uepc_pkg::PID_DATA1}, {8'h00, host.got_q[0]});
      chk("tx byte data1", 16'h0056, {8'h00, host.got_q[1]});
    end else begin
      mismatches++;
      $display("[ERR] tx stream expected last byte seen none");
    end
    report_and_stop();
  end
endmodule : tb_usb_endpoint_rx_ctrl_config_tx_data
`default_nettype wire
